/* File: logic/arcc_pkg.sv */
// Constants and types shared by the alarm and remote calibration block
package arcc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CFG    = 8'h00;
	localparam logic [7:0] OFF_THR1   = 8'h04;
	localparam logic [7:0] OFF_THR2   = 8'h08;
	localparam logic [7:0] OFF_SCALE  = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_CMD    = 8'h14;
	localparam logic [7:0] OFF_RANGE  = 8'h18;

	// Alarm configuration fields, one nibble per threshold alarm
	localparam int CFG_EN     = 0;
	localparam int CFG_HI     = 1;
	localparam int CFG_FS     = 2;
	localparam int CFG_LT     = 3;
	localparam int CFG_STRIDE = 4;
	localparam int CFG_VALVE  = 8;
	localparam int CFG_W      = 9;

	// Status fields
	localparam int ST_ALM   = 0;
	localparam int ST_SYS   = 2;
	localparam int ST_BUSY  = 3;
	localparam int ST_CAL   = 4;
	localparam int ST_ZERO  = 6;
	localparam int ST_SPAN  = 7;

	// Reset values
	localparam logic [8:0]  CFG_RST   = 9'h000;
	localparam logic [15:0] THR_RST   = 16'h0000;
	localparam logic [15:0] SCALE_RST = 16'h0000;

	// Output converter codes
	localparam logic [11:0] DAC_FULL   = 12'hFFF;
	localparam logic [11:0] RID_LOW    = 12'h400;
	localparam logic [11:0] RID_MEDIUM = 12'h800;
	localparam logic [11:0] RID_HIGH   = 12'hC00;
	localparam logic [11:0] RID_AIR    = 12'hFFF;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing
	localparam int          CLK_MHZ     = 100;
	localparam int          DEB_TIME_US = 5000;
	localparam int          DEB_W       = 20;
	localparam logic [19:0] DEB_CYCLES  = 20'(DEB_TIME_US * CLK_MHZ);

	typedef enum logic [1:0] {
		range_low    = 2'b00,
		range_medium = 2'b01,
		range_high   = 2'b10,
		range_air    = 2'b11
	} arcc_range_t;

	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_ZERO = 2'b01,
		CAL_SPAN = 2'b10
	} arcc_cal_t;

endpackage

/* File: logic/arcc_debounce.sv */
// Three-stage synchroniser and debounce filter for one remote input
`timescale 1ns/1ps
module arcc_debounce
	import arcc_pkg::*;
#(
	parameter logic [19:0] CNT = DEB_CYCLES
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic pin_in,
	output logic      level_out
);

	logic             s1_ff;
	logic             s2_ff;
	logic             s3_ff;
	logic [DEB_W-1:0] cnt_ff;
	logic             out_ff;
	logic [DEB_W-1:0] nxt_cnt;
	logic             nxt_out;

	// Only the agreeing later stages are looked at, never s1_ff
	always_comb begin
		nxt_cnt = '0;
		nxt_out = out_ff;
		if (s2_ff == s3_ff && s3_ff != out_ff) begin
			if (cnt_ff >= CNT - 20'h00001) begin
				nxt_out = s3_ff;
			end else begin
				nxt_cnt = cnt_ff + 20'h00001;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s1_ff  <= 1'b0;
			s2_ff  <= 1'b0;
			s3_ff  <= 1'b0;
			cnt_ff <= '0;
			out_ff <= 1'b0;
		end else begin
			s1_ff  <= pin_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
		end
	end

	assign level_out = out_ff;

endmodule

/* File: logic/arcc_top.sv */
// Alarm relays, output scaling and remote calibration control
// Behaviour
// [R1] Threshold alarm high or low type
// [R2] Failsafe inverts relay, nonfailsafe does not
// [R3] Latching holds alarm, nonlatching follows condition
// [R4] Disabled alarm never asserts
// [R5] System alarm always failsafe, latching, enabled
// [R6] Supply fault sets system alarm
// [R7] Self test failure sets system alarm
// [R8] System alarm cleared only by reset
// [R9] Remote zero starts zero calibration
// [R10] Remote span starts span calibration
// [R11] Controller drives external zero valve itself
// [R12] Internal valves follow calibration mode
// [R13] Busy contact asserted during calibration only
// [R14] Idle device polls remote inputs
// [R15] Requests during calibration ignored, not stored
// [R16] Controller commands only while busy deasserted
// [R17] Controller releases command before calibration ends
// [R18] Held command repeats calibration, busy reasserts
// [R19] Range ID quarter, half, three quarters, full
// [R20] Concentration scales linearly to range top
// [R21] Remote inputs synchronised and debounced
// [R22] Controller sequences zero then span
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module arcc_top
	import arcc_pkg::*;
#(
	parameter logic [19:0] DEB_CNT = DEB_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] conc,
	input  wire logic        supply_fault,
	input  wire logic        selftest_fail,
	input  wire logic        cal_done,
	input  wire logic        remote_zero_in,
	input  wire logic        remote_span_in,
	output logic [1:0]       alarm_relay,
	output logic             sys_relay,
	output logic             cal_busy,
	output logic [1:0]       cal_mode,
	output logic             cal_start,
	output logic             valve_zero,
	output logic             valve_span,
	output logic             valve_sample,
	output logic [11:0]      conc_code,
	output logic [11:0]      range_id_code
);

	logic              aw_full_ff, nxt_aw_full;
	logic [7:0]        awaddr_ff, nxt_awaddr;
	logic              w_full_ff, nxt_w_full;
	logic [31:0]       wdata_ff, nxt_wdata;
	logic [3:0]        wstrb_ff, nxt_wstrb;
	logic              bvalid_ff, nxt_bvalid;
	logic [1:0]        bresp_ff, nxt_bresp;
	logic              rvalid_ff, nxt_rvalid;
	logic [31:0]       rdata_ff, nxt_rdata;
	logic [1:0]        rresp_ff, nxt_rresp;
	logic [CFG_W-1:0]  cfg_ff, nxt_cfg;
	logic [15:0]       thr_ff [2];
	logic [15:0]       nxt_thr [2];
	logic [15:0]       scale_ff, nxt_scale;
	arcc_range_t       range_ff, nxt_range;
	logic [1:0]        clr_ff, nxt_clr;
	logic [31:0]       wmerged;
	logic [1:0]        alm_ff, nxt_alm;
	logic [1:0]        relay_ff, nxt_relay;
	logic              sys_ff, nxt_sys;
	logic              sys_relay_ff, nxt_sys_relay;
	logic [31:0]       prod;
	logic [11:0]       conc_code_ff, nxt_conc_code;
	logic [11:0]       rid_ff, nxt_rid;
	arcc_cal_t         cal_ff, nxt_cal;
	logic              busy_ff, nxt_busy;
	logic              start_ff, nxt_start;
	logic              vz_ff, nxt_vz;
	logic              vs_ff, nxt_vs;
	logic              vsm_ff, nxt_vsm;
	logic              zero_db;
	logic              span_db;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return a == OFF_CFG || a == OFF_THR1 || a == OFF_THR2 ||
			a == OFF_SCALE || a == OFF_STATUS || a == OFF_CMD ||
			a == OFF_RANGE;
	endfunction

	function automatic logic [11:0] rid_of(input arcc_range_t r);
		case (r)
			range_low:    return RID_LOW;
			range_medium: return RID_MEDIUM;
			range_high:   return RID_HIGH;
			default:      return RID_AIR;
		endcase
	endfunction

	// Read mux; command register reads zero
	function automatic logic [31:0] reg_word(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h00000000;
		if (a == OFF_CFG) begin
			v[CFG_W-1:0] = cfg_ff;
		end else if (a == OFF_THR1) begin
			v[15:0] = thr_ff[0];
		end else if (a == OFF_THR2) begin
			v[15:0] = thr_ff[1];
		end else if (a == OFF_SCALE) begin
			v[15:0] = scale_ff;
		end else if (a == OFF_STATUS) begin
			v[ST_ALM +: 2] = alm_ff;
			v[ST_SYS]      = sys_ff;
			v[ST_BUSY]     = busy_ff;
			v[ST_CAL +: 2] = cal_ff;
			v[ST_ZERO]     = zero_db;
			v[ST_SPAN]     = span_db;
		end else if (a == OFF_RANGE) begin
			v[1:0] = range_ff;
		end
		return v;
	endfunction

	assign s_axi_awready = !aw_full_ff;
	assign s_axi_wready  = !w_full_ff;
	assign s_axi_arready = !rvalid_ff;

	always_comb begin
		nxt_aw_full = aw_full_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_w_full  = w_full_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb   = wstrb_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_cfg     = cfg_ff;
		nxt_thr     = thr_ff;
		nxt_scale   = scale_ff;
		nxt_range   = range_ff;
		nxt_clr     = 2'h0;
		nxt_rvalid  = rvalid_ff;
		nxt_rdata   = rdata_ff;
		nxt_rresp   = rresp_ff;
		wmerged     = merge(reg_word(awaddr_ff), wdata_ff, wstrb_ff);
		if (s_axi_awvalid && !aw_full_ff) begin
			nxt_aw_full = 1'b1;
			nxt_awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_full_ff) begin
			nxt_w_full = 1'b1;
			nxt_wdata  = s_axi_wdata;
			nxt_wstrb  = s_axi_wstrb;
		end
		if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		// Address and data held until the response slot is free
		if (aw_full_ff && w_full_ff && !bvalid_ff) begin
			nxt_aw_full = 1'b0;
			nxt_w_full  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
			if (awaddr_ff == OFF_CFG) begin
				nxt_cfg = wmerged[CFG_W-1:0];
			end else if (awaddr_ff == OFF_THR1) begin
				nxt_thr[0] = wmerged[15:0];
			end else if (awaddr_ff == OFF_THR2) begin
				nxt_thr[1] = wmerged[15:0];
			end else if (awaddr_ff == OFF_SCALE) begin
				nxt_scale = wmerged[15:0];
			end else if (awaddr_ff == OFF_CMD) begin
				nxt_clr = wmerged[1:0];
			end else if (awaddr_ff == OFF_RANGE) begin
				nxt_range = arcc_range_t'(wmerged[1:0]);
			end
		end
		if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = reg_word(s_axi_araddr);
			nxt_rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aw_full_ff <= 1'b0;
			awaddr_ff  <= 8'h00;
			w_full_ff  <= 1'b0;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			cfg_ff     <= CFG_RST;
			thr_ff[0]  <= THR_RST;
			thr_ff[1]  <= THR_RST;
			scale_ff   <= SCALE_RST;
			range_ff   <= range_low;
			clr_ff     <= 2'h0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= RESP_OKAY;
		end else begin
			aw_full_ff <= nxt_aw_full;
			awaddr_ff  <= nxt_awaddr;
			w_full_ff  <= nxt_w_full;
			wdata_ff   <= nxt_wdata;
			wstrb_ff   <= nxt_wstrb;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			cfg_ff     <= nxt_cfg;
			thr_ff     <= nxt_thr;
			scale_ff   <= nxt_scale;
			range_ff   <= nxt_range;
			clr_ff     <= nxt_clr;
			rvalid_ff  <= nxt_rvalid;
			rdata_ff   <= nxt_rdata;
			rresp_ff   <= nxt_rresp;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// Threshold alarms; condition or'ed in so a new event beats a clear
	for (genvar gi = 0; gi < 2; gi++) begin : g_alarm
		logic cond;
		logic en, hi, fs, lt;
		always_comb begin
			en   = cfg_ff[gi*CFG_STRIDE + CFG_EN];
			hi   = cfg_ff[gi*CFG_STRIDE + CFG_HI];
			fs   = cfg_ff[gi*CFG_STRIDE + CFG_FS];
			lt   = cfg_ff[gi*CFG_STRIDE + CFG_LT];
			cond = hi ? (conc > thr_ff[gi]) : (conc < thr_ff[gi]); // [R1]
			nxt_alm[gi] = en & (cond | (lt & alm_ff[gi] & !clr_ff[gi])); // [R3]
			nxt_relay[gi] = fs ? !nxt_alm[gi] : nxt_alm[gi]; // [R2]
		end
	end

	// System alarm: set-only, energised while healthy
	always_comb begin
		nxt_sys       = sys_ff | supply_fault | selftest_fail; // [R6] [R7]
		nxt_sys_relay = !nxt_sys; // [R5]
		prod          = conc * scale_ff;
		// Scale is top-of-range reciprocal so no divider is needed
		nxt_conc_code = (prod[31:28] != 4'h0) ? DAC_FULL : prod[27:16]; // [R20]
		nxt_rid       = rid_of(range_ff); // [R19]
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			alm_ff       <= 2'h0;
			relay_ff     <= 2'h0;
			sys_ff       <= 1'b0; // [R8]
			sys_relay_ff <= 1'b1;
			conc_code_ff <= 12'h000;
			rid_ff       <= RID_LOW;
		end else begin
			alm_ff       <= nxt_alm;
			relay_ff     <= nxt_relay;
			sys_ff       <= nxt_sys;
			sys_relay_ff <= nxt_sys_relay;
			conc_code_ff <= nxt_conc_code;
			rid_ff       <= nxt_rid;
		end
	end

	assign alarm_relay   = relay_ff;
	assign sys_relay     = sys_relay_ff;
	assign conc_code     = conc_code_ff;
	assign range_id_code = rid_ff;

	arcc_debounce #(.CNT(DEB_CNT)) u_deb_zero ( // [R21]
		.clock     (clock),
		.resetn    (resetn),
		.pin_in    (remote_zero_in),
		.level_out (zero_db)
	);

	arcc_debounce #(.CNT(DEB_CNT)) u_deb_span ( // [R21]
		.clock     (clock),
		.resetn    (resetn),
		.pin_in    (remote_span_in),
		.level_out (span_db)
	);

	// Inputs are only looked at in idle, so nothing is queued
	always_comb begin
		nxt_cal   = cal_ff;
		nxt_start = 1'b0;
		case (cal_ff)
			CAL_IDLE: begin // [R14]
				if (zero_db) begin // [R9]
					nxt_cal   = CAL_ZERO;
					nxt_start = 1'b1;
				end else if (span_db) begin // [R10]
					nxt_cal   = CAL_SPAN;
					nxt_start = 1'b1;
				end
			end
			CAL_ZERO, CAL_SPAN: begin // [R15]
				// One idle cycle lets a held command restart visibly
				if (cal_done) begin // [R18]
					nxt_cal = CAL_IDLE;
				end
			end
			default: begin
				nxt_cal = CAL_IDLE;
			end
		endcase
		nxt_busy = nxt_cal != CAL_IDLE; // [R13]
		nxt_vz   = cfg_ff[CFG_VALVE] & (nxt_cal == CAL_ZERO); // [R12]
		nxt_vs   = cfg_ff[CFG_VALVE] & (nxt_cal == CAL_SPAN); // [R12]
		nxt_vsm  = cfg_ff[CFG_VALVE] & (nxt_cal == CAL_IDLE); // [R12]
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cal_ff   <= CAL_IDLE;
			busy_ff  <= 1'b0;
			start_ff <= 1'b0;
			vz_ff    <= 1'b0;
			vs_ff    <= 1'b0;
			vsm_ff   <= 1'b0;
		end else begin
			cal_ff   <= nxt_cal;
			busy_ff  <= nxt_busy;
			start_ff <= nxt_start;
			vz_ff    <= nxt_vz;
			vs_ff    <= nxt_vs;
			vsm_ff   <= nxt_vsm;
		end
	end

	assign cal_busy     = busy_ff;
	assign cal_mode     = cal_ff;
	assign cal_start    = start_ff;
	assign valve_zero   = vz_ff;
	assign valve_span   = vs_ff;
	assign valve_sample = vsm_ff;

	high_type_a: assert property ( // [R1]
		cfg_ff[CFG_EN] && cfg_ff[CFG_HI] && !cfg_ff[CFG_LT] &&
		conc > thr_ff[0] |=> alm_ff[0])
		else $error("high alarm did not assert");
	low_type_a: assert property ( // [R1]
		cfg_ff[CFG_EN] && !cfg_ff[CFG_HI] && !cfg_ff[CFG_LT] &&
		conc >= thr_ff[0] |=> !alm_ff[0])
		else $error("low alarm asserted at or above threshold");
	failsafe_relay_a: assert property ( // [R2]
		relay_ff[0] == (alm_ff[0] ^ $past(cfg_ff[CFG_FS])))
		else $error("alarm relay polarity wrong");
	latch_hold_a: assert property ( // [R3]
		cfg_ff[CFG_EN] && cfg_ff[CFG_LT] && alm_ff[0] && !clr_ff[0]
		|=> alm_ff[0])
		else $error("latched alarm dropped");
	disabled_alarm_a: assert property ( // [R4]
		!cfg_ff[CFG_STRIDE + CFG_EN] |=> !alm_ff[1])
		else $error("disabled alarm asserted");
	sys_relay_a: assert property ( // [R5]
		sys_relay == !sys_ff)
		else $error("system relay not failsafe");
	sys_set_a: assert property ( // [R6]
		supply_fault || selftest_fail |=> sys_ff [*3])
		else $error("system alarm not set and held");
	sys_hold_a: assert property ( // [R8]
		$rose(sys_ff) |-> ##1 sys_ff [*8])
		else $error("system alarm cleared without reset");
	zero_start_a: assert property ( // [R9]
		cal_ff == CAL_IDLE && zero_db |=> cal_ff == CAL_ZERO && cal_start)
		else $error("zero request not taken");
	span_start_a: assert property ( // [R10]
		cal_ff == CAL_IDLE && !zero_db && span_db |=> cal_ff == CAL_SPAN)
		else $error("span request not taken");
	valve_follow_a: assert property ( // [R12]
		cfg_ff[CFG_VALVE] && $stable(cfg_ff) |->
		valve_zero == (cal_ff == CAL_ZERO) &&
		valve_sample == (cal_ff == CAL_IDLE))
		else $error("internal valves out of step");
	busy_mode_a: assert property ( // [R13]
		cal_busy == (cal_mode != CAL_IDLE))
		else $error("busy contact disagrees with mode");
	cal_ignore_a: assert property ( // [R15]
		cal_ff == CAL_ZERO && !cal_done |=> cal_ff == CAL_ZERO)
		else $error("calibration left early");
	cal_repeat_a: assert property ( // [R18]
		cal_ff == CAL_SPAN && cal_done ##1 span_db && !zero_db
		|=> cal_busy && cal_ff == CAL_SPAN)
		else $error("held span did not repeat");
	range_id_a: assert property ( // [R19]
		range_ff == range_medium |=> range_id_code == RID_MEDIUM)
		else $error("range id code wrong");

endmodule

/* File: verif/arcc_ctrl_model.sv */
// Process controller model driving the remote calibration inputs
`timescale 1ns/1ps
module arcc_ctrl_model (
	input  wire logic clock,
	input  wire logic cal_busy,
	output logic      zero_cmd,
	output logic      span_cmd
);
	logic [1:0] cmd = 2'b00;
	logic       timed_out = 1'b0;

	// Driven low when off, so a released line reads 0
	assign zero_cmd = cmd[0];
	assign span_cmd = cmd[1];

	task automatic wait_busy(input logic lvl);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge clock);
			if (cal_busy === lvl) break;
		end
		if (i == 3000) timed_out = 1'b1;
	endtask

	// One command, issued only while idle, released once acknowledged
	task automatic run(input logic span, input int hold);
		wait_busy(1'b0);
		@(posedge clock);
		cmd[span] <= 1'b1;
		wait_busy(1'b1);
		repeat (hold) @(posedge clock);
		@(posedge clock);
		cmd[span] <= 1'b0;
		wait_busy(1'b0);
	endtask

	// Deliberate span request while busy, outside the polling window
	task automatic poke(input int len);
		@(posedge clock);
		cmd[1] <= 1'b1;
		repeat (len) @(posedge clock);
		cmd[1] <= 1'b0;
	endtask

	// Combined calibration, strictly zero then span
	task automatic combined();
		run(1'b0, 0);
		run(1'b1, 0);
	endtask
endmodule

/* File: verif/arcc_top_tb.sv */
// Self-checking bench for the alarm and remote calibration block
`timescale 1ns/1ps
module arcc_top_tb import arcc_pkg::*;;
	logic        clock, resetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, alarm_relay, cal_mode;
	logic [15:0] conc;
	logic        supply_fault, selftest_fail, cal_done, zero_in, span_in;
	logic        sys_relay, cal_busy, cal_start;
	logic        valve_zero, valve_span, valve_sample;
	logic [11:0] conc_code, range_id_code;
	int          errors = 0;
	int          n_tests = 0;
	int          done_dly = 30;
	int          done_cnt = 0;
	int          starts = 0;
	int          m, j, n0;
	logic [31:0] seed = 32'h2FC2;
	logic [8:0]  cfg;
	logic [15:0] thr [2];
	logic        st [2];
	logic [15:0] seq [5] = '{16'h0800, 16'h1000, 16'h1001, 16'h0FFF, 16'h1000};
	logic [11:0] rid [4] = '{RID_LOW, RID_MEDIUM, RID_HIGH, RID_AIR};
	longint      e;

	arcc_top #(.DEB_CNT(20'h4)) arcc_top_inst (
		.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .conc(conc), .supply_fault(supply_fault),
		.selftest_fail(selftest_fail), .cal_done(cal_done),
		.remote_zero_in(zero_in), .remote_span_in(span_in),
		.alarm_relay(alarm_relay), .sys_relay(sys_relay),
		.cal_busy(cal_busy), .cal_mode(cal_mode), .cal_start(cal_start),
		.valve_zero(valve_zero), .valve_span(valve_span),
		.valve_sample(valve_sample), .conc_code(conc_code),
		.range_id_code(range_id_code));

	arcc_ctrl_model arcc_ctrl_model_inst (.clock(clock),
		.cal_busy(cal_busy), .zero_cmd(zero_in), .span_cmd(span_in));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Calibration engine stand-in: finishes done_dly cycles after a start
	always @(posedge clock) begin
		cal_done <= 1'b0;
		if (cal_start === 1'b1) begin
			starts <= starts + 1;
			done_cnt <= done_dly;
		end else if (done_cnt > 0) begin
			done_cnt <= done_cnt - 1;
			if (done_cnt == 1) cal_done <= 1'b1;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic conclude();
		$display("Counts: %0d checks, %0d errors", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp,
		input string what);
		chk_bus(32'(got), 32'(exp), what);
	endtask

	task automatic fail_to(input string what);
		errors++;
		$display("mismatch at %0t: %s timed out", $time, what);
		conclude();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int i;
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge clock);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(negedge clock);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r  = bresp;
			@(posedge clock);
			if (ta === 1'b1) awvalid <= 1'b0;
			if (tw === 1'b1) wvalid <= 1'b0;
			if (tb === 1'b1) break;
		end
		bready <= 1'b0;
		if (i == 100) fail_to("write");
		chk_bus(32'(r), 32'(er), "write resp");
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int i;
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clock);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(negedge clock);
			ta = arvalid & arready;
			tr = rvalid;
			d  = rdata;
			r  = rresp;
			@(posedge clock);
			if (ta === 1'b1) arvalid <= 1'b0;
			if (tr === 1'b1) break;
		end
		rready <= 1'b0;
		if (i == 100) fail_to("read");
		chk_bus(d, ed, "read data");
		chk_bus(32'(r), 32'(er), "read resp");
	endtask

	task automatic wait_busy(input logic lvl);
		int i;
		for (i = 0; i < 3000; i++) begin
			@(negedge clock);
			if (cal_busy === lvl) break;
		end
		if (i == 3000) fail_to("busy");
	endtask

	// Settle a concentration, optionally clear latches, compare relays
	task automatic alarm_step(input logic [15:0] c, input logic [1:0] clr);
		logic [3:0] f;
		logic cond;
		@(posedge clock);
		conc <= c;
		repeat (3) @(posedge clock);
		if (clr != 2'b00) wr(OFF_CMD, 32'(clr), RESP_OKAY);
		repeat (3) @(posedge clock);
		@(negedge clock);
		for (int k = 0; k < 2; k++) begin
			f = cfg[k * CFG_STRIDE +: 4];
			cond = f[CFG_HI] ? (c > thr[k]) : (c < thr[k]);
			st[k] = f[CFG_EN] & (cond | f[CFG_LT] & st[k]);
			st[k] = f[CFG_EN] & (cond | f[CFG_LT] & st[k] & !clr[k]);
			chk_pin(alarm_relay[k], f[CFG_FS] ? !st[k] : st[k], "relay");
		end
		chk_pin(sys_relay, 1'b1, "healthy sys relay");
	endtask

	task automatic do_reset();
		@(posedge clock);
		resetn <= 1'b0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		@(negedge clock);
	endtask

	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, conc} = '0;
		{supply_fault, selftest_fail} = '0;
		wstrb = 4'hF;
		st = '{1'b0, 1'b0};
		do_reset();
		chk_pin(range_id_code, RID_LOW, "range id reset");
		chk_pin(sys_relay, 1'b1, "sys relay reset");
		for (m = 0; m < 8'h1C; m += 4) rd(8'(m), 32'h0, RESP_OKAY);
		rd(8'h1C, 32'h0, RESP_SLVERR);
		wr(8'h80, 32'hFFFF, RESP_SLVERR);
		wr(OFF_STATUS, 32'hFF, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		for (j = 0; j < 6; j++) begin
			seed = lfsr(seed);
			if (j == 4) seed[31:16] = 16'h0;
			if (j == 5) seed = 32'hFFFFFFFF;
			wr(OFF_RANGE, 32'(j % 4), RESP_OKAY);
			wr(OFF_SCALE, 32'(seed[15:0]), RESP_OKAY);
			rd(OFF_SCALE, 32'(seed[15:0]), RESP_OKAY);
			conc <= seed[31:16];
			repeat (4) @(posedge clock);
			@(negedge clock);
			e = (longint'(seed[31:16]) * seed[15:0]) >> 16;
			chk_pin(range_id_code, rid[j % 4], "range id");
			chk_pin(conc_code, (e > 4095) ? DAC_FULL : 12'(e), "conc");
		end
		for (m = 0; m < 16; m++) begin
			seed = lfsr(seed);
			cfg = {1'b0, seed[3:0], 4'(m)};
			thr[0] = 16'h1000;
			thr[1] = 16'h0FFF + 16'(seed[17:16]);
			wr(OFF_CFG, 32'(cfg), RESP_OKAY);
			wr(OFF_THR1, 32'(thr[0]), RESP_OKAY);
			wr(OFF_THR2, 32'(thr[1]), RESP_OKAY);
			for (j = 0; j < 5; j++) alarm_step(seq[j], (j == 0) ? 2'b11 : 2'b00);
			alarm_step(seed[31:16], 2'b11);
		end
		for (m = 0; m < 4; m++) begin
			wr(OFF_CFG, 32'(m[1]) << CFG_VALVE, RESP_OKAY);
			n0 = starts;
			fork
				arcc_ctrl_model_inst.run(m[0], 0);
				begin
					wait_busy(1'b1);
					chk_pin(cal_mode, m[0] ? CAL_SPAN : CAL_ZERO, "mode");
					chk_pin(valve_zero, m[1] & !m[0], "zero valve");
					chk_pin(valve_span, m[1] & m[0], "span valve");
					chk_pin(valve_sample, 1'b0, "sample valve");
					if (m == 2) arcc_ctrl_model_inst.poke(10);
				end
			join
			repeat (40) @(posedge clock);
			@(negedge clock);
			chk_pin(cal_busy, 1'b0, "busy after");
			chk_pin(valve_sample, m[1], "sample valve idle");
			chk_bus(32'(starts - n0), 32'h1, "starts");
		end
		done_dly = 15;
		n0 = starts;
		arcc_ctrl_model_inst.run(1'b1, 10);
		repeat (60) @(posedge clock);
		chk_bus(32'(starts - n0), 32'h2, "repeat starts");
		n0 = starts;
		arcc_ctrl_model_inst.combined();
		repeat (40) @(posedge clock);
		@(negedge clock);
		chk_bus(32'(starts - n0), 32'h2, "combined starts");
		chk_pin(cal_busy, 1'b0, "busy idle");
		chk_pin(arcc_ctrl_model_inst.timed_out, 1'b0, "partner wait");
		for (m = 0; m < 2; m++) begin
			@(posedge clock);
			supply_fault  <= !m[0];
			selftest_fail <= m[0];
			@(posedge clock);
			supply_fault  <= 1'b0;
			selftest_fail <= 1'b0;
			repeat (20) @(posedge clock);
			@(negedge clock);
			chk_pin(sys_relay, 1'b0, "sys alarm held");
			rd(OFF_STATUS, 32'h1 << ST_SYS, RESP_OKAY);
			do_reset();
			chk_pin(sys_relay, 1'b1, "sys alarm cleared");
		end
		conclude();
	end
endmodule
